/* File: hdl/ssfa_device.sv */
// SPI slave frame access: device end with memory, interrupts and init delay
// What this block does
// - Sample on rising, drive on falling clock
// - Either clock idle level accepted
// - Frame: address, op bit, length, data
// - Op bit zero reads, one writes
// - Length one single, more is burst
// - Frame decoding starts after select falls
// - Master ends frame by raising select
// - Drive output low until read data
// - Third byte op and high length
// - One stored byte per dummy byte
// - Interrupt on socket and wake events
// - Write-one clears status; per-source masks
// - Reset input held low over 500 ns
// - Initialisation done within 60.3 ms
module ssfa_device #(
	parameter int INIT_CYCLES = ssfa_pkg::INIT_CYCLES
) (
	// System
	input wire logic clk,
	input wire logic reset,
	// Serial link
	ssfa_if.dev link,
	// Network events, one-cycle pulses
	input wire logic evt_connect,
	input wire logic evt_disconnect,
	input wire logic evt_timeout,
	input wire logic evt_wol,
	// Status
	output logic init_done
);
	localparam logic [ssfa_pkg::CNT_W-1:0] INIT_LAST =
		ssfa_pkg::CNT_W'(INIT_CYCLES - ssfa_pkg::SYNC_LAT);

	logic [2:0] sclk_s_q;
	logic [2:0] cs_s_q;
	logic [1:0] mosi_s_q;
	logic [1:0] reset_in_low_s_q;
	logic [ssfa_pkg::CNT_W-1:0] init_cnt_q;
	logic init_done_q;
	ssfa_pkg::ssfa_dev_state_e state_q, state_d;
	logic [4:0] bit_cnt_q, bit_cnt_d;
	logic [ssfa_pkg::HDR_BITS-1:0] sr_q;
	logic [ssfa_pkg::ADDR_W-1:0] addr_q, addr_d;
	logic rw_q, rw_d;
	logic [ssfa_pkg::LEN_W-1:0] remain_q, remain_d;
	logic load_q, load_d;
	logic [7:0] tx_q;
	logic miso_q, miso_d;
	logic miso_oe_q, miso_oe_d;
	logic [7:0] girq_stat_q, girq_mask_q, sirq_stat_q, sirq_mask_q;
	logic irq_low_q;
	logic [7:0] mem [ssfa_pkg::MEM_BYTES];

	// Pin synchronisers; the extra stage keeps history for edges
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sclk_s_q <= 3'h0;
			cs_s_q <= 3'h7;
			mosi_s_q <= 2'h0;
			reset_in_low_s_q <= 2'h0;
		end else begin
			sclk_s_q <= {sclk_s_q[1:0], link.sclk};
			cs_s_q <= {cs_s_q[1:0], link.chip_select_low};
			mosi_s_q <= {mosi_s_q[0], link.mosi};
			reset_in_low_s_q <= {reset_in_low_s_q[0], link.reset_in_low};
		end
	end

	// Edge and field decode
	wire dev_hold = ~reset_in_low_s_q[1];
	wire sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
	wire sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
	wire cs_fall = ~cs_s_q[1] & cs_s_q[2];
	wire cs_rise = cs_s_q[1] & ~cs_s_q[2];
	wire [ssfa_pkg::HDR_BITS-1:0] shift_in = {sr_q[30:0], mosi_s_q[1]};
	wire [ssfa_pkg::ADDR_W-1:0] hdr_addr = shift_in[31:16];
	wire hdr_rw = shift_in[ssfa_pkg::HDR_RW_POS];
	wire [ssfa_pkg::LEN_W-1:0] hdr_len = shift_in[14:0];
	wire [7:0] wr_byte = shift_in[7:0];
	wire byte_end = (state_q == ssfa_pkg::DEV_DATA) && sclk_rise &&
		(bit_cnt_q[2:0] == ssfa_pkg::BYTE_LAST);
	wire wr_en = byte_end && (rw_q == ssfa_pkg::RW_WRITE);
	wire mem_sel = addr_q[15:8] == ssfa_pkg::MEM_PAGE;

	// Read data selection
	wire [7:0] rd_data = mem_sel ? mem[addr_q[ssfa_pkg::MEM_AW-1:0]] :
		(addr_q == ssfa_pkg::GIRQ_STAT_ADDR) ? girq_stat_q :
		(addr_q == ssfa_pkg::GIRQ_MASK_ADDR) ? girq_mask_q :
		(addr_q == ssfa_pkg::SIRQ_STAT_ADDR) ? sirq_stat_q :
		(addr_q == ssfa_pkg::SIRQ_MASK_ADDR) ? sirq_mask_q : 8'h00;

	// Interrupt set and clear terms
	wire [7:0] girq_set = {7'h00, evt_wol} << ssfa_pkg::GIRQ_WOL_BIT;
	wire [7:0] sirq_set = ({7'h00, evt_connect} << ssfa_pkg::SIRQ_CON_BIT) |
		({7'h00, evt_disconnect} << ssfa_pkg::SIRQ_DISCON_BIT) |
		({7'h00, evt_timeout} << ssfa_pkg::SIRQ_TIMEOUT_BIT);
	wire [7:0] girq_clr = (wr_en && addr_q == ssfa_pkg::GIRQ_STAT_ADDR) ? wr_byte : 8'h00;
	wire [7:0] sirq_clr = (wr_en && addr_q == ssfa_pkg::SIRQ_STAT_ADDR) ? wr_byte : 8'h00;
	wire irq_any = |((girq_stat_q & girq_mask_q) | (sirq_stat_q & sirq_mask_q));

	// Initialisation delay after reset input release
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			init_cnt_q <= '0;
			init_done_q <= 1'b0;
		end else if (dev_hold) begin
			init_cnt_q <= '0;
			init_done_q <= 1'b0;
		end else if (!init_done_q) begin
			init_cnt_q <= init_cnt_q + 1'b1;
			init_done_q <= init_cnt_q == INIT_LAST;
		end
	end

	// Frame engine next state
	always_comb begin
		state_d = state_q;
		bit_cnt_d = bit_cnt_q;
		addr_d = addr_q;
		rw_d = rw_q;
		remain_d = remain_q;
		load_d = 1'b0;
		miso_d = miso_q;
		miso_oe_d = miso_oe_q;
		if (cs_rise || dev_hold) begin
			state_d = ssfa_pkg::DEV_IDLE;
			miso_d = 1'b0;
			miso_oe_d = 1'b0;
		end else begin
			case (state_q)
				ssfa_pkg::DEV_IDLE: begin
					// Clock level ignored while idle
					if (cs_fall && init_done_q) begin
						state_d = ssfa_pkg::DEV_HDR;
						bit_cnt_d = 5'h00;
						miso_d = 1'b0;
						miso_oe_d = 1'b1;
					end
				end
				ssfa_pkg::DEV_HDR: begin
					if (sclk_rise) begin
						bit_cnt_d = bit_cnt_q + 5'h01;
						if (bit_cnt_q == ssfa_pkg::HDR_LAST) begin
							addr_d = hdr_addr;
							rw_d = hdr_rw;
							remain_d = hdr_len;
							load_d = 1'b1;
							bit_cnt_d = 5'h00;
							state_d = (hdr_len == '0) ? ssfa_pkg::DEV_DONE :
								ssfa_pkg::DEV_DATA;
						end
					end
				end
				ssfa_pkg::DEV_DATA: begin
					if (byte_end) begin
						bit_cnt_d = 5'h00;
						addr_d = addr_q + 16'h0001;
						remain_d = remain_q - 15'h0001;
						load_d = 1'b1;
						if (remain_q == 15'h0001) begin
							state_d = ssfa_pkg::DEV_DONE;
						end
					end else if (sclk_rise) begin
						bit_cnt_d = bit_cnt_q + 5'h01;
					end else if (sclk_fall && rw_q == ssfa_pkg::RW_READ) begin
						miso_d = tx_q[7];
					end
				end
				ssfa_pkg::DEV_DONE: begin
					miso_d = 1'b0;
				end
				default: begin
					state_d = ssfa_pkg::DEV_IDLE;
				end
			endcase
		end
	end

	// Frame engine registers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q <= ssfa_pkg::DEV_IDLE;
			bit_cnt_q <= 5'h00;
			addr_q <= '0;
			rw_q <= ssfa_pkg::RW_READ;
			remain_q <= '0;
			load_q <= 1'b0;
			miso_q <= 1'b0;
			miso_oe_q <= 1'b0;
		end else begin
			state_q <= state_d;
			bit_cnt_q <= bit_cnt_d;
			addr_q <= addr_d;
			rw_q <= rw_d;
			remain_q <= remain_d;
			load_q <= load_d;
			miso_q <= miso_d;
			miso_oe_q <= miso_oe_d;
		end
	end

	// Input shifter and output byte
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sr_q <= '0;
			tx_q <= 8'h00;
		end else begin
			if (sclk_rise) begin
				sr_q <= shift_in;
			end
			if (load_q) begin
				tx_q <= rd_data;
			end else if (state_q == ssfa_pkg::DEV_DATA && sclk_fall) begin
				tx_q <= {tx_q[6:0], 1'b0};
			end
		end
	end

	// Byte memory, written at each completed write byte that falls in its page
	always_ff @(posedge clk) begin
		if (wr_en && mem_sel) begin
			mem[addr_q[ssfa_pkg::MEM_AW-1:0]] <= wr_byte;
		end
	end

	// Sticky status with masks; set wins over clear
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			girq_stat_q <= ssfa_pkg::IRQ_RESET;
			sirq_stat_q <= ssfa_pkg::IRQ_RESET;
			girq_mask_q <= ssfa_pkg::IRQ_RESET;
			sirq_mask_q <= ssfa_pkg::IRQ_RESET;
			irq_low_q <= 1'b1;
		end else if (dev_hold) begin
			girq_stat_q <= ssfa_pkg::IRQ_RESET;
			sirq_stat_q <= ssfa_pkg::IRQ_RESET;
			girq_mask_q <= ssfa_pkg::IRQ_RESET;
			sirq_mask_q <= ssfa_pkg::IRQ_RESET;
			irq_low_q <= 1'b1;
		end else begin
			girq_stat_q <= (girq_stat_q & ~girq_clr) | girq_set;
			sirq_stat_q <= (sirq_stat_q & ~sirq_clr) | sirq_set;
			if (wr_en && addr_q == ssfa_pkg::GIRQ_MASK_ADDR) begin
				girq_mask_q <= wr_byte;
			end
			if (wr_en && addr_q == ssfa_pkg::SIRQ_MASK_ADDR) begin
				sirq_mask_q <= wr_byte;
			end
			irq_low_q <= ~irq_any;
		end
	end

	// Outputs
	assign link.miso = miso_q;
	assign link.miso_oe = miso_oe_q;
	assign link.irq_out_low = irq_low_q;
	assign init_done = init_done_q;
endmodule // ssfa_device

/* File: hdl/ssfa_pkg.sv */
// Shared constants and state types for the SPI frame access link
package ssfa_pkg;
	// Clock and link timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int RESET_HOLD_NS = 500;
	localparam int RESET_HOLD_CYCLES = RESET_HOLD_NS / CLK_PERIOD_NS + 1;
	localparam int INIT_TIME_NS = 60_300_000;
	localparam int INIT_CYCLES = INIT_TIME_NS / CLK_PERIOD_NS;
	localparam int SYNC_LAT = 3;
	localparam int SCLK_PERIOD_NS = 80;
	localparam int SCLK_HALF_CYCLES = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int CNT_W = 24;
	localparam int DIV_W = 3;
	// Frame layout
	localparam int ADDR_W = 16;
	localparam int LEN_W = 15;
	localparam int BYTE_W = 8;
	localparam int HDR_BITS = 32;
	localparam int HDR_RW_POS = 15;
	localparam logic [4:0] HDR_LAST = 5'h1F;
	localparam logic [2:0] BYTE_LAST = 3'h7;
	localparam logic RW_READ = 1'b0;
	localparam logic RW_WRITE = 1'b1;
	// Device address map
	localparam int MEM_AW = 8;
	localparam int MEM_BYTES = 256;
	localparam logic [7:0] MEM_PAGE = 8'h01;
	localparam logic [15:0] GIRQ_STAT_ADDR = 16'h0000;
	localparam logic [15:0] GIRQ_MASK_ADDR = 16'h0001;
	localparam logic [15:0] SIRQ_STAT_ADDR = 16'h0002;
	localparam logic [15:0] SIRQ_MASK_ADDR = 16'h0003;
	localparam logic [7:0] IRQ_RESET = 8'h00;
	localparam int GIRQ_WOL_BIT = 0;
	localparam int SIRQ_CON_BIT = 0;
	localparam int SIRQ_DISCON_BIT = 1;
	localparam int SIRQ_TIMEOUT_BIT = 2;
	// Device frame engine and master sequencer states
	typedef enum logic [1:0] {DEV_IDLE, DEV_HDR, DEV_DATA, DEV_DONE} ssfa_dev_state_e;
	typedef enum logic [2:0] {
		HST_RST, HST_INIT, HST_IDLE, HST_SETUP, HST_SHIFT, HST_GAP
	} ssfa_host_state_e;
endpackage

/* File: hdl/ssfa_if.sv */
// Serial link pins between the access port and its master
interface ssfa_if;
	logic sclk;
	logic chip_select_low;
	logic mosi;
	logic miso;
	logic miso_oe;
	logic irq_out_low;
	logic reset_in_low;
	modport dev (
		input sclk, chip_select_low, mosi, reset_in_low,
		output miso, miso_oe, irq_out_low
	);
	modport host (
		output sclk, chip_select_low, mosi, reset_in_low,
		input miso, miso_oe, irq_out_low
	);
endinterface

/* File: hdl/ssfa_host.sv */
// SPI frame access: master end with reset pulse, init wait and framing
module ssfa_host #(
	parameter int INIT_CYCLES = ssfa_pkg::INIT_CYCLES
) (
	// System
	input wire logic clk,
	input wire logic reset,
	// Serial link
	ssfa_if.host link,
	// Control
	input wire logic mode3,
	input wire logic rst_req,
	// Command
	input wire logic cmd_valid,
	input wire logic cmd_rw,
	input wire logic [15:0] cmd_addr,
	input wire logic [14:0] cmd_len,
	output logic cmd_ready,
	// Write data
	input wire logic [7:0] wr_data,
	output logic wr_take,
	// Read data
	output logic rd_valid,
	output logic [7:0] rd_data
);
	localparam logic [ssfa_pkg::CNT_W-1:0] HOLD_LAST =
		ssfa_pkg::CNT_W'(ssfa_pkg::RESET_HOLD_CYCLES - 1);
	localparam logic [ssfa_pkg::CNT_W-1:0] INIT_LAST = ssfa_pkg::CNT_W'(INIT_CYCLES - 1);
	localparam logic [ssfa_pkg::DIV_W-1:0] DIV_LAST =
		ssfa_pkg::DIV_W'(ssfa_pkg::SCLK_HALF_CYCLES - 1);

	ssfa_pkg::ssfa_host_state_e state_q;
	logic [ssfa_pkg::CNT_W-1:0] cnt_q;
	logic [ssfa_pkg::DIV_W-1:0] div_q;
	logic [1:0] miso_s_q;
	logic sclk_q, cs_low_q, rst_low_q, cpol_q, risen_q, hdr_q, rw_q;
	logic [ssfa_pkg::HDR_BITS-1:0] sr_q;
	logic [4:0] bits_q;
	logic [ssfa_pkg::LEN_W-1:0] remain_q;
	logic [7:0] rx_q;
	logic ready_q, take_q, rd_valid_q;
	logic [7:0] rd_data_q;

	// Half-period enable and decode
	wire tick = div_q == '0;
	wire [7:0] rx_next = {rx_q[6:0], miso_s_q[1]};
	wire unit_end = bits_q == 5'h00;
	wire [7:0] next_tx = (rw_q == ssfa_pkg::RW_WRITE) ? wr_data : 8'h00;
	wire last_data = ~hdr_q && remain_q == 15'h0001;
	wire hdr_empty = hdr_q && remain_q == '0;
	// Last unit ends here; mode 3 keeps the clock high for the select rise
	wire frame_end = risen_q && unit_end && (last_data || hdr_empty);

	// Divider and data-in synchroniser
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			div_q <= '0;
			miso_s_q <= 2'h0;
		end else begin
			div_q <= tick ? DIV_LAST : div_q - 1'b1;
			miso_s_q <= {miso_s_q[0], link.miso};
		end
	end

	// Master sequencer
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q <= ssfa_pkg::HST_RST;
			cnt_q <= '0;
			sclk_q <= 1'b0;
			cs_low_q <= 1'b1;
			rst_low_q <= 1'b0;
			cpol_q <= 1'b0;
			risen_q <= 1'b0;
			hdr_q <= 1'b0;
			rw_q <= ssfa_pkg::RW_READ;
			sr_q <= '0;
			bits_q <= 5'h00;
			remain_q <= '0;
			rx_q <= 8'h00;
			ready_q <= 1'b0;
			take_q <= 1'b0;
			rd_valid_q <= 1'b0;
			rd_data_q <= 8'h00;
		end else begin
			take_q <= 1'b0;
			rd_valid_q <= 1'b0;
			case (state_q)
				ssfa_pkg::HST_RST: begin
					rst_low_q <= 1'b0;
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q == HOLD_LAST) begin
						rst_low_q <= 1'b1;
						cnt_q <= '0;
						state_q <= ssfa_pkg::HST_INIT;
					end
				end
				ssfa_pkg::HST_INIT: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q == INIT_LAST) begin
						ready_q <= 1'b1;
						state_q <= ssfa_pkg::HST_IDLE;
					end
				end
				ssfa_pkg::HST_IDLE: begin
					sclk_q <= mode3;
					cs_low_q <= 1'b1;
					if (rst_req) begin
						ready_q <= 1'b0;
						rst_low_q <= 1'b0;
						cnt_q <= '0;
						state_q <= ssfa_pkg::HST_RST;
					end else if (cmd_valid) begin
						ready_q <= 1'b0;
						cpol_q <= mode3;
						rw_q <= cmd_rw;
						remain_q <= cmd_len;
						sr_q <= {cmd_addr, cmd_rw, cmd_len};
						bits_q <= ssfa_pkg::HDR_LAST;
						hdr_q <= 1'b1;
						risen_q <= 1'b0;
						cs_low_q <= 1'b0;
						state_q <= ssfa_pkg::HST_SETUP;
					end
				end
				ssfa_pkg::HST_SETUP: begin
					if (tick) begin
						state_q <= ssfa_pkg::HST_SHIFT;
					end
				end
				ssfa_pkg::HST_SHIFT: begin
					if (tick && !sclk_q) begin
						sclk_q <= 1'b1;
						risen_q <= 1'b1;
					end else if (tick) begin
						sclk_q <= frame_end ? cpol_q : 1'b0;
						if (risen_q) begin
							risen_q <= 1'b0;
							rx_q <= rx_next;
							if (!unit_end) begin
								bits_q <= bits_q - 5'h01;
								sr_q <= {sr_q[30:0], 1'b0};
							end else begin
								if (!hdr_q && rw_q == ssfa_pkg::RW_READ) begin
									rd_valid_q <= 1'b1;
									rd_data_q <= rx_next;
								end
								if (!hdr_q) begin
									remain_q <= remain_q - 15'h0001;
								end
								hdr_q <= 1'b0;
								if (last_data || hdr_empty) begin
									state_q <= ssfa_pkg::HST_GAP;
								end else begin
									sr_q <= {next_tx, 24'h000000};
									take_q <= rw_q == ssfa_pkg::RW_WRITE;
									bits_q <= {2'h0, ssfa_pkg::BYTE_LAST};
								end
							end
						end
					end
				end
				ssfa_pkg::HST_GAP: begin
					cs_low_q <= 1'b1;
					sclk_q <= cpol_q;
					if (tick) begin
						ready_q <= 1'b1;
						state_q <= ssfa_pkg::HST_IDLE;
					end
				end
				default: begin
					state_q <= ssfa_pkg::HST_IDLE;
				end
			endcase
		end
	end

	// Outputs
	assign link.sclk = sclk_q;
	assign link.chip_select_low = cs_low_q;
	assign link.mosi = sr_q[ssfa_pkg::HDR_BITS-1];
	assign link.reset_in_low = rst_low_q;
	assign cmd_ready = ready_q;
	assign wr_take = take_q;
	assign rd_valid = rd_valid_q;
	assign rd_data = rd_data_q;
endmodule // ssfa_host

/* File: verification/ssfa_checker.sv */
// Concurrent checks on the serial link pins between the two ends
module ssfa_checker #(
	parameter int INIT_CYCLES = 64
) (
	// System
	input wire logic clk,
	input wire logic reset,
	// Link pins
	input wire logic sclk,
	input wire logic chip_select_low,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe,
	input wire logic irq_out_low,
	input wire logic reset_in_low
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic [15:0] rise_q;
	logic [15:0] low_q;
	logic [15:0] up_q;
	logic [3:0] idle_q;
	// Clock rises in frame, device reset length, time since reset and idle time
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rise_q <= 16'h0000;
			low_q <= 16'h0000;
			up_q <= 16'h0000;
			idle_q <= 4'h0;
		end else begin
			// A level change that lands with the select fall is no data edge
			rise_q <= chip_select_low ? 16'h0000 :
				rise_q + 16'($rose(sclk) && !$fell(chip_select_low));
			low_q <= reset_in_low ? 16'h0000 : low_q + 16'h0001;
			up_q <= !reset_in_low ? 16'h0000 : up_q + 16'(up_q != 16'hFFFF);
			idle_q <= !chip_select_low ? 4'h0 : idle_q + 4'(idle_q != 4'hF);
		end
	end
	a_sclk_idle_still: assert property (chip_select_low && $past(chip_select_low) |-> $stable(sclk))
		else $error("serial clock moved while deselected");
	a_half_period: assert property ($changed(sclk) && !chip_select_low |=> $stable(sclk) [*3])
		else $error("serial clock half period too short");
	a_mosi_low_phase: assert property ($changed(mosi) && !chip_select_low && !$past(chip_select_low) |-> !sclk)
		else $error("mosi changed in high clock phase");
	a_oe_idle_off: assert property (chip_select_low [*6] |-> !miso_oe)
		else $error("miso driven while deselected");
	a_hdr_miso_low: assert property (!chip_select_low && miso_oe && rise_q < 16'd32 |-> !miso)
		else $error("miso not low during header");
	a_whole_bytes: assert property ($rose(chip_select_low) |-> rise_q >= 16'd32 && rise_q[2:0] == 3'h0)
		else $error("frame ended inside a unit");
	a_reset_hold: assert property ($rose(reset_in_low) |-> low_q > 16'h0032)
		else $error("device reset pulse too short");
	a_init_wait: assert property ($fell(chip_select_low) |-> up_q + 16'd2 >= 16'(INIT_CYCLES))
		else $error("frame started before initialisation time");
	a_irq_clear_cause: assert property ($rose(irq_out_low) |-> idle_q < 4'h8 || !$past(reset_in_low, 3))
		else $error("interrupt released without a frame");
	c_mode3_frame: cover property ($fell(chip_select_low) && sclk);
	c_read_one: cover property (miso_oe && miso && rise_q > 16'd32);
	c_irq_low: cover property ($fell(irq_out_low));
endmodule // ssfa_checker

/* File: verification/tb.sv */
// Self-checking bench joining the master and device ends of the frame link
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int INIT_N = 64;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic mode3 = 1'b0;
	logic rst_req = 1'b0;
	logic cmd_valid = 1'b0;
	logic cmd_rw = 1'b0;
	logic [15:0] cmd_addr = 16'h0000;
	logic [14:0] cmd_len = 15'h0000;
	logic [7:0] wr_data = 8'h00;
	logic [3:0] evt = 4'h0;
	logic cmd_ready, wr_take, rd_valid, init_done;
	logic [7:0] rd_data;
	logic [7:0] mem [256];
	logic [7:0] regs [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] wbuf [9];
	int err_total = 0;
	int n_checks = 0;
	int seed = 32'h5747;
	int cyc = 0;
	ssfa_if i_ssfa_if ();
	ssfa_host #(.INIT_CYCLES(INIT_N)) i_ssfa_host (.clk(clk), .reset(reset),
		.link(i_ssfa_if.host), .mode3(mode3), .rst_req(rst_req), .cmd_valid(cmd_valid),
		.cmd_rw(cmd_rw), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_ready(cmd_ready),
		.wr_data(wr_data), .wr_take(wr_take), .rd_valid(rd_valid), .rd_data(rd_data));
	ssfa_device #(.INIT_CYCLES(INIT_N)) i_ssfa_device (.clk(clk), .reset(reset),
		.link(i_ssfa_if.dev), .evt_connect(evt[0]), .evt_disconnect(evt[1]),
		.evt_timeout(evt[2]), .evt_wol(evt[3]), .init_done(init_done));
	ssfa_checker #(.INIT_CYCLES(INIT_N)) i_ssfa_checker (.clk(clk), .reset(reset),
		.sclk(i_ssfa_if.sclk), .chip_select_low(i_ssfa_if.chip_select_low),
		.mosi(i_ssfa_if.mosi), .miso(i_ssfa_if.miso), .miso_oe(i_ssfa_if.miso_oe),
		.irq_out_low(i_ssfa_if.irq_out_low), .reset_in_low(i_ssfa_if.reset_in_low));
	// System clock
	initial begin
		forever #5 clk = ~clk;
	end
	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_total++;
			close_out();
		end
	end
	// Verdict and end of run
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Compare one value
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Expected read byte from memory and control places
	function automatic logic [7:0] exp_byte(input logic [15:0] a);
		if (a[15:8] == ssfa_pkg::MEM_PAGE) return mem[a[7:0]];
		if (a < 16'h0004) return regs[a[1:0]];
		return 8'h00;
	endfunction
	// Wait for the master to accept commands
	task automatic wait_ready();
		repeat (500) begin
			if (cmd_ready === 1'b1) return;
			@(posedge clk);
			#1;
		end
		check(8'(cmd_ready), 8'h01);
	endtask
	// One whole frame through the master, random clock mode
	task automatic frame(input logic rw, input logic [15:0] a, input int n);
		int k;
		int w;
		logic tk;
		logic [15:0] wa;
		k = 0;
		w = 0;
		tk = 1'b0;
		wait_ready();
		cmd_rw = rw;
		cmd_addr = a;
		cmd_len = 15'(n);
		mode3 = 1'($random(seed));
		wr_data = wbuf[0];
		cmd_valid = 1'b1;
		@(posedge clk);
		#1;
		cmd_valid = 1'b0;
		repeat (3000) begin
			if (cmd_ready === 1'b1) break;
			@(posedge clk);
			#1;
			if (tk) wr_data = wbuf[w];
			tk = (wr_take === 1'b1);
			if (tk) w++;
			if (rd_valid === 1'b1) begin
				check(rd_data, exp_byte(a + 16'(k)));
				k++;
			end
		end
		check(8'(cmd_ready), 8'h01);
		check(8'(rw ? w : k), 8'(n));
		for (int i = 0; i < n && rw; i++) begin
			wa = a + 16'(i);
			if (wa[15:8] == ssfa_pkg::MEM_PAGE) mem[wa[7:0]] = wbuf[i];
			else if (wa < 16'h0004 && wa[0]) regs[wa[1:0]] = wbuf[i];
			else if (wa < 16'h0004) regs[wa[1:0]] = regs[wa[1:0]] & ~wbuf[i];
		end
	endtask
	// One-cycle event pulse, then the interrupt pin is compared
	task automatic pulse(input logic [3:0] e, input logic [7:0] irq_exp);
		evt = e;
		regs[0] = regs[0] | {7'h00, e[3]};
		regs[2] = regs[2] | {5'h00, e[2:0]};
		@(posedge clk);
		#1;
		evt = 4'h0;
		repeat (4) @(posedge clk);
		#1;
		check(8'(i_ssfa_if.irq_out_low), irq_exp);
	endtask
	// Main sequence
	initial begin
		logic [15:0] a;
		int n;
		repeat (5) @(posedge clk);
		#1;
		reset = 1'b0;
		check(8'(i_ssfa_if.reset_in_low), 8'h00);
		check(8'(i_ssfa_if.irq_out_low), 8'h01);
		wait_ready();
		check(8'(init_done), 8'h01);
		for (int t = 0; t < 12; t++) begin
			a = {ssfa_pkg::MEM_PAGE, 8'($unsigned($random(seed)) % 248)};
			n = (t < 2) ? 1 : 1 + $unsigned($random(seed)) % 6;
			if (t == 0) a = 16'h01FF;
			for (int i = 0; i < 8; i++) wbuf[i] = 8'($random(seed));
			frame(1'b1, a, n);
			frame(1'b0, a, n);
		end
		frame(1'b0, 16'h2000, 3);
		frame(1'b0, 16'h0100, 0);
		pulse(4'h4, 8'h01);
		wbuf[0] = 8'hFF;
		frame(1'b1, ssfa_pkg::SIRQ_STAT_ADDR, 1);
		wbuf[0] = 8'h01;
		wbuf[1] = 8'h00;
		wbuf[2] = 8'h07;
		frame(1'b1, ssfa_pkg::GIRQ_MASK_ADDR, 3);
		for (int i = 0; i < 4; i++) begin
			a = (i == 3) ? ssfa_pkg::GIRQ_STAT_ADDR : ssfa_pkg::SIRQ_STAT_ADDR;
			pulse(4'(1 << i), 8'h00);
			frame(1'b0, a, 1);
			wbuf[0] = (i == 3) ? 8'h01 : 8'(1 << i);
			frame(1'b1, a, 1);
			check(8'(i_ssfa_if.irq_out_low), 8'h01);
		end
		pulse(4'h1, 8'h00);
		wait_ready();
		rst_req = 1'b1;
		@(posedge clk);
		#1;
		rst_req = 1'b0;
		regs = '{8'h00, 8'h00, 8'h00, 8'h00};
		repeat (4) @(posedge clk);
		#1;
		check(8'(i_ssfa_if.reset_in_low), 8'h00);
		frame(1'b0, 16'h0000, 4);
		check(8'(i_ssfa_if.irq_out_low), 8'h01);
		close_out();
	end
endmodule // tb
